/* verilog/php_consts.vh */
`ifndef PHP_CONSTS_VH
`define PHP_CONSTS_VH
`define PHP_CLK_NS 50
`define PHP_TICK_NS 10000000
`define PHP_A_PICK0 8'h00
`define PHP_A_PICK1 8'h04
`define PHP_A_DLY0 8'h08
`define PHP_A_DLY1 8'h0c
`define PHP_A_THR2 8'h10
`define PHP_A_DLY2 8'h14
`define PHP_A_THR5 8'h18
`define PHP_A_DLY3 8'h1c
`define PHP_A_EVEN 8'h20
`define PHP_A_ISTAT 8'h24
`define PHP_A_ICLR 8'h28
`define PHP_A_IEN 8'h2c
`define PHP_A_STATE 8'h30
`define PHP_A_POWER 8'h34
`define PHP_A_SCNT 4'h4
`define PHP_A_TCNT 4'h5
`define PHP_A_FLT 4'h6
`define PHP_A_ELAPSED_DELAY_PERCENT 4'h7
`define PHP_A_RATIO 4'h8
`define PHP_PICK0_RST 16'hffd8
`define PHP_PICK1_RST 16'hff38
`define PHP_PICK_MIN 16'hf830
`define PHP_PICK_MAX 16'h07d0
`define PHP_PDLY_RST 16'h0064
`define PHP_PDLY_MIN 16'h001e
`define PHP_HDLY_RST 16'h0005
`define PHP_HDLY_MIN 16'h0005
`define PHP_DLY_MAX 16'h7530
`define PHP_THR_RST 8'h0a
`define PHP_THR_MIN 8'h0a
`define PHP_THR_MAX 8'h64
`define PHP_PCT 8'h64
`endif

/* verilog/php_stages.v */
`timescale 1ns/10ps
`include "php_consts.vh"

module php_stages #(
  parameter TICK_CYCLES = `PHP_TICK_NS / `PHP_CLK_NS
) (
  input wire clk_i, // device clock
  input wire rst_i, // synchronous reset
  input wire cyc_i, // wishbone cycle
  input wire stb_i, // wishbone strobe
  input wire we_i, // wishbone write
  input wire [7:0] adr_i, // byte address
  input wire [3:0] sel_i, // byte selects
  input wire [31:0] dat_i, // write data
  output reg [31:0] dat_o, // read data
  output reg ack_o, // wishbone ack
  input wire [15:0] power_i, // signed active power, 0.1 % of nominal
  input wire [15:0] ph1_fund_i, // phase 1 fundamental
  input wire [15:0] ph2_fund_i, // phase 2 fundamental
  input wire [15:0] ph3_fund_i, // phase 3 fundamental
  input wire [15:0] ph1_h2_i, // phase 1 second harmonic
  input wire [15:0] ph2_h2_i, // phase 2 second harmonic
  input wire [15:0] ph3_h2_i, // phase 3 second harmonic
  input wire [15:0] ph1_h5_i, // phase 1 fifth harmonic
  input wire [15:0] ph2_h5_i, // phase 2 fifth harmonic
  input wire [15:0] ph3_h5_i, // phase 3 fifth harmonic
  output reg [3:0] start_o, // start per stage
  output reg [3:0] trip_o, // trip per stage
  output reg [15:0] event_o, // gated event pulses
  output reg irq_o // level interrupt
);

  // settings
  reg [15:0] pick0;
  reg [15:0] pick1;
  reg [63:0] dly;
  reg [7:0] thr2;
  reg [7:0] thr5;
  reg [15:0] ev_en;
  reg [15:0] irq_stat;
  reg [15:0] irq_en;
  reg [15:0] power;
  reg [95:0] ratio;
  reg [63:0] elapsed_delay_percent;
  reg [17:0] tick_cnt;
  reg tick;
  wire [63:0] scnt;
  wire [63:0] tcnt;
  wire [63:0] flt;
  wire [63:0] elapsed;
  wire [3:0] cond;
  wire [63:0] val;
  wire [3:0] next_start;
  wire [3:0] next_trip;
  wire [15:0] ev_raw;
  wire wr;
  wire [15:0] wd;
  wire [15:0] h2max;
  wire [15:0] h5max;

  assign wr = cyc_i & stb_i & we_i & ~ack_o;
  assign wd = dat_i[15:0];

  // fixed time base for all delay timers
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 18'h00000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 18'h00000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 18'h00001;
      tick <= 1'b0;
    end
  end

  // measured power, kept for readback and comparisons
  always @(posedge clk_i) begin
    if (rst_i) begin
      power <= 16'h0000;
    end else begin
      power <= power_i;
    end
  end

  // shared serial divider: jobs 0..5 harmonic ratios, 6..9 elapsed percent
  reg [3:0] job;
  reg [4:0] bitn;
  reg busy;
  reg [23:0] quo;
  reg [16:0] rem;
  reg [15:0] dvs;
  reg zero_dvs;
  wire [47:0] fund3;
  wire [95:0] harm6;
  reg [15:0] num;
  reg [15:0] den;
  wire [16:0] trial;
  wire [15:0] res;
  assign fund3 = {ph3_fund_i, ph2_fund_i, ph1_fund_i};
  assign harm6 = {ph3_h5_i, ph2_h5_i, ph1_h5_i, ph3_h2_i, ph2_h2_i, ph1_h2_i};
  assign trial = {rem[15:0], quo[23]} - {1'b0, dvs};
  assign res = zero_dvs ? 16'h0000 : ((|quo[23:16]) ? 16'hffff : quo[15:0]);

  // operand select for the next job
  always @* begin
    num = 16'h0000;
    den = 16'h0000;
    if (job < 4'd6) begin
      num = harm6[job*16 +: 16];
      den = fund3[(job % 3)*16 +: 16];
    end else begin
      num = elapsed[(job-6)*16 +: 16];
      den = dly[(job-6)*16 +: 16];
    end
  end

  // restoring division, 24 steps per job, result saturates
  always @(posedge clk_i) begin
    if (rst_i) begin
      job <= 4'h0;
      bitn <= 5'h00;
      busy <= 1'b0;
      quo <= 24'h000000;
      rem <= 17'h00000;
      dvs <= 16'h0000;
      zero_dvs <= 1'b1;
      ratio <= 96'h0;
      elapsed_delay_percent <= 64'h0;
    end else if (!busy) begin
      quo <= num * `PHP_PCT;
      rem <= 17'h00000;
      dvs <= den;
      zero_dvs <= (den == 16'h0000);
      bitn <= 5'h00;
      busy <= 1'b1;
    end else if (bitn != 5'd24) begin
      if (!trial[16]) begin
        rem <= trial;
      end else begin
        rem <= {rem[15:0], quo[23]};
      end
      quo <= {quo[22:0], ~trial[16]};
      bitn <= bitn + 5'h01;
    end else begin
      busy <= 1'b0;
      job <= (job == 4'd9) ? 4'h0 : job + 4'h1;
      if (job < 4'd6) begin
        ratio[job*16 +: 16] <= res;
      end else if (start_o[job-6]) begin
        elapsed_delay_percent[(job-6)*16 +: 16] <= res; // value held once the fault ends
      end
    end
  end

  // largest ratio across the three phases
  function [15:0] max3;
    input [47:0] v;
    reg [15:0] m;
    begin
      m = v[15:0];
      if (v[31:16] > m) m = v[31:16];
      if (v[47:32] > m) m = v[47:32];
      max3 = m;
    end
  endfunction
  assign h2max = max3(ratio[47:0]);
  assign h5max = max3(ratio[95:48]);

  // stage conditions
  assign cond[0] = $signed(power) < $signed(pick0);
  assign cond[1] = $signed(power) < $signed(pick1);
  assign cond[2] = h2max > {8'h00, thr2};
  assign cond[3] = h5max > {8'h00, thr5};
  assign val = {h5max, h2max, power, power};

  // one timer, counter set and recorder per stage
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : stg
      reg [15:0] cnt;
      reg [15:0] sc;
      reg [15:0] tc;
      reg [15:0] fv;
      wire [15:0] d;
      wire worse;
      assign d = dly[g*16 +: 16];
      assign elapsed[g*16 +: 16] = cnt;
      assign scnt[g*16 +: 16] = sc;
      assign tcnt[g*16 +: 16] = tc;
      assign flt[g*16 +: 16] = fv;
      // power faults keep the lowest value, harmonic faults the highest
      assign worse = (g < 2) ? ($signed(val[g*16 +: 16]) < $signed(fv))
                             : (val[g*16 +: 16] > fv);
      assign next_start[g] = cond[g];
      assign next_trip[g] = cond[g] & (trip_o[g] | (cnt >= d));
      assign ev_raw[g*4 +: 4] = {trip_o[g] & ~next_trip[g], next_trip[g] & ~trip_o[g],
                                 start_o[g] & ~next_start[g], next_start[g] & ~start_o[g]};
      always @(posedge clk_i) begin
        if (rst_i) begin
          cnt <= 16'h0000;
          sc <= 16'h0000;
          tc <= 16'h0000;
          fv <= 16'h0000;
        end else begin
          if (!cond[g]) begin
            cnt <= 16'h0000;
          end else if (tick && cnt < d) begin
            cnt <= cnt + 16'h0001;
          end
          if (next_start[g] && !start_o[g]) begin
            sc <= sc + 16'h0001;
            fv <= val[g*16 +: 16];
          end else if (start_o[g] && worse) begin
            fv <= val[g*16 +: 16];
          end
          if (next_trip[g] && !trip_o[g]) begin
            tc <= tc + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // stage outputs, usable as blocking signals elsewhere
  always @(posedge clk_i) begin
    if (rst_i) begin
      start_o <= 4'h0;
      trip_o <= 4'h0;
      event_o <= 16'h0000;
    end else begin
      start_o <= next_start;
      trip_o <= next_trip;
      event_o <= ev_raw & ev_en;
    end
  end

  // clamp helpers for setting writes
  function [15:0] clamp_u;
    input [15:0] v;
    input [15:0] lo;
    begin
      clamp_u = (v < lo) ? lo : ((v > `PHP_DLY_MAX) ? `PHP_DLY_MAX : v);
    end
  endfunction
  function [7:0] clamp_thr;
    input [15:0] v;
    begin
      if (v < {8'h00, `PHP_THR_MIN}) clamp_thr = `PHP_THR_MIN;
      else if (v > {8'h00, `PHP_THR_MAX}) clamp_thr = `PHP_THR_MAX;
      else clamp_thr = v[7:0];
    end
  endfunction
  function [15:0] clamp_pick;
    input [15:0] v;
    begin
      if ($signed(v) < $signed(`PHP_PICK_MIN)) clamp_pick = `PHP_PICK_MIN;
      else if ($signed(v) > $signed(`PHP_PICK_MAX)) clamp_pick = `PHP_PICK_MAX;
      else clamp_pick = v;
    end
  endfunction

  // setting registers, low half-word lanes only
  always @(posedge clk_i) begin
    if (rst_i) begin
      pick0 <= `PHP_PICK0_RST;
      pick1 <= `PHP_PICK1_RST;
      dly <= {`PHP_HDLY_RST, `PHP_HDLY_RST, `PHP_PDLY_RST, `PHP_PDLY_RST};
      thr2 <= `PHP_THR_RST;
      thr5 <= `PHP_THR_RST;
      ev_en <= 16'hffff;
      irq_en <= 16'h0000;
    end else if (wr && sel_i[1:0] == 2'b11) begin
      case (adr_i)
        `PHP_A_PICK0: pick0 <= clamp_pick(wd);
        `PHP_A_PICK1: pick1 <= clamp_pick(wd);
        `PHP_A_DLY0: dly[15:0] <= clamp_u(wd, `PHP_PDLY_MIN);
        `PHP_A_DLY1: dly[31:16] <= clamp_u(wd, `PHP_PDLY_MIN);
        `PHP_A_THR2: thr2 <= clamp_thr(wd);
        `PHP_A_DLY2: dly[47:32] <= clamp_u(wd, `PHP_HDLY_MIN);
        `PHP_A_THR5: thr5 <= clamp_thr(wd);
        `PHP_A_DLY3: dly[63:48] <= clamp_u(wd, `PHP_HDLY_MIN);
        `PHP_A_EVEN: ev_en <= wd;
        `PHP_A_IEN: irq_en <= wd;
        default: ;
      endcase
    end
  end

  // sticky event status; a new event wins over a clear in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 16'h0000;
      irq_o <= 1'b0;
    end else begin
      if (wr && adr_i == `PHP_A_ICLR) begin
        irq_stat <= (irq_stat & ~wd) | (ev_raw & ev_en);
      end else begin
        irq_stat <= irq_stat | (ev_raw & ev_en);
      end
      irq_o <= |(irq_stat & irq_en);
    end
  end

  // bus answer one cycle after the request, reads registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h00000000;
      if (cyc_i && stb_i && !we_i && !ack_o) begin
        case (adr_i[7:4])
          `PHP_A_SCNT: dat_o[15:0] <= scnt[adr_i[3:2]*16 +: 16];
          `PHP_A_TCNT: dat_o[15:0] <= tcnt[adr_i[3:2]*16 +: 16];
          `PHP_A_FLT: dat_o[15:0] <= flt[adr_i[3:2]*16 +: 16];
          `PHP_A_ELAPSED_DELAY_PERCENT: dat_o[15:0] <= elapsed_delay_percent[adr_i[3:2]*16 +: 16];
          `PHP_A_RATIO: dat_o[15:0] <= ratio[adr_i[3:2]*16 +: 16];
          4'h9: dat_o[15:0] <= (adr_i[3] ? 16'h0000 : ratio[(adr_i[2] + 4)*16 +: 16]);
          default: begin
            case (adr_i)
              `PHP_A_PICK0: dat_o[15:0] <= pick0;
              `PHP_A_PICK1: dat_o[15:0] <= pick1;
              `PHP_A_DLY0: dat_o[15:0] <= dly[15:0];
              `PHP_A_DLY1: dat_o[15:0] <= dly[31:16];
              `PHP_A_THR2: dat_o[7:0] <= thr2;
              `PHP_A_DLY2: dat_o[15:0] <= dly[47:32];
              `PHP_A_THR5: dat_o[7:0] <= thr5;
              `PHP_A_DLY3: dat_o[15:0] <= dly[63:48];
              `PHP_A_EVEN: dat_o[15:0] <= ev_en;
              `PHP_A_ISTAT: dat_o[15:0] <= irq_stat;
              `PHP_A_IEN: dat_o[15:0] <= irq_en;
              `PHP_A_STATE: dat_o[7:0] <= {trip_o, start_o};
              `PHP_A_POWER: dat_o[15:0] <= power;
              default: dat_o <= 32'h00000000;
            endcase
          end
        endcase
      end
    end
  end

endmodule // php_stages

/* verification/php_stages_asserts.sv */
`timescale 1ns/10ps
module php_stages_asserts #(
  parameter TICK_CYCLES = 200000
) (
  input wire clk_i, // device clock
  input wire rst_i, // synchronous reset
  input wire cyc_i, // bus cycle
  input wire stb_i, // bus strobe
  input wire [31:0] dat_o, // read data
  input wire ack_o, // bus ack
  input wire [15:0] power_i, // signed power
  input wire [3:0] start_o, // stage starts
  input wire [3:0] trip_o, // stage trips
  input wire [15:0] event_o // gated events
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus handshake and idle data
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");
  // any pick-up in range starts below -200 percent and never at +200 percent
  // power is registered once and start once more, so starts show two clocks later
  property p_deep_start; $signed(power_i) < -2000 |-> ##2 start_o[1:0] == 2'b11; endproperty
  a_deep_start: assert property (p_deep_start) else $error("power start missing");
  property p_high_idle; $signed(power_i) >= 2000 |-> ##2 start_o[1:0] == 2'b00; endproperty
  a_high_idle: assert property (p_high_idle) else $error("power start spurious");
  // stage ordering and events
  property p_trip_start; (trip_o & ~start_o) == 4'h0; endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  property p_ev_srise; event_o[0] |-> $rose(start_o[0]); endproperty
  a_ev_srise: assert property (p_ev_srise) else $error("start event misplaced");
  property p_ev_trise; event_o[10] |-> $rose(trip_o[2]); endproperty
  a_ev_trise: assert property (p_ev_trise) else $error("trip event misplaced");
  property p_trip_hold; $rose(trip_o[3]) |-> $past(start_o[3], 8); endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip too early");
  property p_fall_clear; $fell(start_o[0]) |-> !trip_o[0]; endproperty
  a_fall_clear: assert property (p_fall_clear) else $error("trip outlived start");
  c_trip0: cover property (trip_o[0]);
  c_trip3: cover property (trip_o[3]);
  c_read: cover property (ack_o && dat_o != 32'h0);
endmodule // php_stages_asserts
bind php_stages php_stages_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_php_chk (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .power_i(power_i), .start_o(start_o), .trip_o(trip_o), .event_o(event_o));

/* verification/php_meas_model.sv */
`timescale 1ns/10ps
module php_meas_model (
  input wire clk_i, // sample clock
  input wire [15:0] power_set_i, // wanted power
  input wire [15:0] fund_set_i, // wanted fundamental
  input wire [15:0] h2_set_i, // wanted phase 3 second harmonic
  input wire [15:0] h5_set_i, // wanted phase 1 fifth harmonic
  output reg [15:0] power_o = 16'h0, // measured power
  output reg [15:0] fund_o = 16'h0, // measured fundamental
  output reg [15:0] h2_o = 16'h0, // measured second harmonic
  output reg [15:0] h5_o = 16'h0 // measured fifth harmonic
);
  // measurement chain refreshes once per clock, one clock late
  always @(posedge clk_i) begin
    power_o <= power_set_i;
    fund_o <= fund_set_i;
    h2_o <= h2_set_i;
    h5_o <= h5_set_i;
  end
endmodule // php_meas_model

/* verification/power_and_harmonic_protection_stages_bench.sv */
`timescale 1ns/10ps
module power_and_harmonic_protection_stages_bench;
  localparam TICK = 4;
  localparam LIMIT = 20000;
  reg clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] dat = 32'h0, rd;
  reg [15:0] pw_set = 16'h07d0, fund_set = 16'h03e8, h2_set = 16'h0, h5_set = 16'h0;
  reg [15:0] ev_seen = 16'h0;
  wire [31:0] rdat;
  wire ack, irq;
  wire [3:0] start, trip;
  wire [15:0] ev, pw, fund, h2, h5;
  integer errors = 0, check_count = 0, cycles = 0, n;
  php_meas_model i_php_meas_model (.clk_i(clk), .power_set_i(pw_set), .fund_set_i(fund_set),
    .h2_set_i(h2_set), .h5_set_i(h5_set), .power_o(pw), .fund_o(fund), .h2_o(h2), .h5_o(h5));
  php_stages #(.TICK_CYCLES(TICK)) i_php_stages (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .power_i(pw), .ph1_fund_i(fund), .ph2_fund_i(fund), .ph3_fund_i(fund), .ph1_h2_i(16'h0),
    .ph2_h2_i(16'h0), .ph3_h2_i(h2), .ph1_h5_i(h5), .ph2_h5_i(16'h0), .ph3_h5_i(16'h0),
    .start_o(start), .trip_o(trip), .event_o(ev), .irq_o(irq));
  // clock, watchdog and event collector
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      wrap_up;
    end
  end
  always @(posedge clk) ev_seen <= ev_seen | ev;
  task wrap_up;
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle, entered just after a rising edge; leaves one idle cycle
  task wb(input bit w, input [7:0] a, input [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  task rchk(input string nm, input [7:0] a, input [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("pick0", 8'h00, 32'h0000ffd8);
    rchk("pick1", 8'h04, 32'h0000ff38);
    rchk("dly0", 8'h08, 32'h00000064);
    rchk("thr2", 8'h10, 32'h0000000a);
    rchk("dly2", 8'h14, 32'h00000005);
    rchk("evens", 8'h20, 32'h0000ffff);
    rchk("unmapped", 8'hfc, 32'h0);
    rchk("power", 8'h34, 32'h000007d0);
    wb(1'b1, 8'h00, 32'h00008000);
    rchk("pick0 low", 8'h00, 32'h0000f830);
    wb(1'b1, 8'h00, 32'h0000ffd8);
    wb(1'b1, 8'h08, 32'h00000001);
    rchk("dly0 low", 8'h08, 32'h0000001e);
    wb(1'b1, 8'h10, 32'h000000ff);
    rchk("thr2 high", 8'h10, 32'h00000064);
    wb(1'b1, 8'h10, 32'h0000000a);
    wb(1'b1, 8'h2c, 32'h00000001);
    // short underpower spell clears before trip
    pw_set <= 16'hffce;
    while (start[0] !== 1'b1) @(posedge clk);
    repeat (10) @(posedge clk);
    pw_set <= 16'h07d0;
    while (start[0] !== 1'b0) @(posedge clk);
    chk("trip early", trip[0], 1'b0);
    chk("irq up", irq, 1'b1);
    rchk("istat", 8'h24, 32'h00000003);
    wb(1'b1, 8'h28, 32'h00000003);
    repeat (2) @(posedge clk);
    chk("irq clr", irq, 1'b0);
    // held spell trips after the full delay, timer restarted
    pw_set <= 16'hffce;
    while (start[0] !== 1'b1) @(posedge clk);
    n = 0;
    while (trip[0] !== 1'b1) begin
      @(posedge clk);
      n = n + 1;
    end
    chk("trip delay", 32'(n >= 29 * TICK && n <= 31 * TICK), 32'h1);
    wb(1'b1, 8'h2c, 32'h0);
    chk("irq mask", irq, 1'b0);
    wb(1'b1, 8'h28, 32'h0000ffff);
    rchk("scnt0", 8'h40, 32'h2);
    rchk("tcnt0", 8'h50, 32'h1);
    rchk("flt0", 8'h60, 32'h0000ffce);
    // elapsed percent refreshes once per divider round, let one full round pass
    repeat (300) @(posedge clk);
    rchk("edly0", 8'h70, 32'h00000064);
    pw_set <= 16'h07d0;
    while (start[0] !== 1'b0) @(posedge clk);
    // both stages, stage two start-rise event masked
    wb(1'b1, 8'h20, 32'h0000ffef);
    @(negedge clk) ev_seen = 16'h0;
    @(posedge clk) pw_set <= 16'hf7cc;
    while (start[1:0] !== 2'b11) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("ev masked", {ev_seen[4], ev_seen[0]}, 2'b01);
    rchk("state", 8'h30, 32'h00000003);
    pw_set <= 16'h07d0;
    rchk("scnt1", 8'h44, 32'h1);
    rchk("flt1", 8'h64, 32'h0000f7cc);
    // second harmonic, equal ratio does not start
    h2_set <= 16'h0064;
    repeat (600) @(posedge clk);
    chk("h2 equal", start[2], 1'b0);
    rchk("ratio2", 8'h88, 32'h0000000a);
    h2_set <= 16'h006e;
    while (trip[2] !== 1'b1) @(posedge clk);
    rchk("ratio2 up", 8'h88, 32'h0000000b);
    rchk("flt2", 8'h68, 32'h0000000b);
    repeat (300) @(posedge clk);
    rchk("edly2", 8'h78, 32'h00000064);
    h2_set <= 16'h0;
    // fifth harmonic on another phase
    h5_set <= 16'h00c8;
    while (trip[3] !== 1'b1) @(posedge clk);
    rchk("ratio5", 8'h8c, 32'h00000014);
    h5_set <= 16'h0;
    while (start[3] !== 1'b0) @(posedge clk);
    rchk("scnt3", 8'h4c, 32'h1);
    rchk("tcnt3", 8'h5c, 32'h1);
    wrap_up;
  end
endmodule // power_and_harmonic_protection_stages_bench
